// ### pkg/rmh_consts.svh
`ifndef RMH_CONSTS_SVH
`define RMH_CONSTS_SVH
`define RMH_IP_START     16'h0800
`define RMH_STEP1        16'h0800
`define RMH_STEP2        16'h1000
`define RMH_STEP3        16'h2000
`define RMH_STEP4        16'h4000
`define RMH_SEL_IP       1'b0
`define RMH_SEL_SA       1'b1
`define RMH_D_OWN        31
`define RMH_D_FLAG       30
`define RMH_W0_CLEN      13:11
`define RMH_W0_RLEN      10:8
`define RMH_W0_ARM       7
`define RMH_W0_VEC       6:0
`define RMH_W2_POLL      15
`define RMH_W2_HIGH      5:0
`define RMH_W3_GO        0
`define RMH_W3_LAST      1
`define RMH_W3_BURST     7:2
`define RMH_NOCHK_BYTES  16'h003C
`define RMH_F_RAM        16'hAB0B
`define RMH_F_CACHE      16'hAD0B
`define RMH_F_BUS        16'hAF0B
`define RMH_F_CLR        16'hB00B
`define RMH_F_PARITY     16'hB60B
`define RMH_CLK_NS       5
`define RMH_FLASH_MS     250
`endif

// ### pkg/rmh_pkg.sv
package rmh_pkg;
  typedef enum logic [1:0] {
    RMH_MAINT_MSG_TYPE,
    RMH_CREDIT_MSG_TYPE,
    RMH_DATAGRAM_MSG_TYPE,
    RMH_SEQUENTIAL_MSG_TYPE
  } rmh_msg_t;
  typedef enum logic [4:0] {
    S_IDLE, S_STEP1, S_STEP2, S_STEP3, S_STEP4, S_DTEST, S_CLR, S_RUN,
    S_CDESC, S_CENV0, S_CENV1, S_CDONE,
    S_RDESC, S_RBUF, S_RENV0, S_RENV1, S_RDONE, S_XFER, S_FATAL
  } rmh_state_t;
endpackage

// ### logic/rmh_ring_idx.sv
`timescale 1ns/100ps
module rmh_ring_idx #(
  parameter int W = 7
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst,      // Sync reset
  input  wire logic         clr,      // Back to slot zero
  input  wire logic         adv,      // Step to next slot
  input  wire logic [2:0]   len_log2, // Ring length as power of two
  output logic      [W-1:0] idx_q     // Current slot
);
  logic [W-1:0] last;

  initial
  begin
    if (W < 1 || W > 7)
      $error("rmh_ring_idx: W must be 1..7");
  end

  // Ring wraps to zero after its last slot
  assign last = W'((32'd1 << len_log2) - 32'd1);

  always_ff @(posedge clk)
  begin
    if (rst || clr)
      idx_q <= '0;
    else if (adv)
      idx_q <= (idx_q == last) ? '0 : idx_q + W'(1);
  end
endmodule

// ### logic/rmh_fault.sv
`timescale 1ns/100ps
`include "rmh_consts.svh"
module rmh_fault #(
  parameter int FLASH_CYC = 50000000
) (
  input  wire logic        clk,        // System clock
  input  wire logic        rst,        // Sync reset or reinit
  input  wire logic        ram_fail,   // Buffer RAM test failure
  input  wire logic        cache_fail, // Cache test failure
  input  wire logic        bus_fail,   // Mastership or access failure
  input  wire logic        parity,     // Bus parity error
  output logic             fatal_q,    // Fatal fault latched
  output logic      [15:0] code_q,     // First fault code
  output logic             led_q       // Flashing error indicator
);
  logic [31:0] cnt_q;

  initial
  begin
    if (FLASH_CYC < 1)
      $error("rmh_fault: FLASH_CYC must be positive");
  end

  // First fault wins so the code names the root cause
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fatal_q <= 1'b0;
      code_q  <= 16'h0000;
    end
    else if (!fatal_q && (ram_fail || cache_fail || bus_fail || parity))
    begin
      fatal_q <= 1'b1;
      code_q  <= ram_fail ? `RMH_F_RAM : cache_fail ? `RMH_F_CACHE :
                 parity ? `RMH_F_PARITY : `RMH_F_BUS;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !fatal_q)
    begin
      cnt_q <= 32'h0000_0000;
      led_q <= 1'b0;
    end
    else if (cnt_q == 32'(FLASH_CYC - 1))
    begin
      cnt_q <= 32'h0000_0000;
      led_q <= !led_q;
    end
    else
      cnt_q <= cnt_q + 32'h0000_0001;
  end
endmodule

// ### logic/rmh_port.sv
// Operation
// - Command and response rings of 32-bit descriptors
// - Envelope address bit zero always taken zero
// - Returned descriptors carry flag set
// - Flag requests transition interrupt when armed
// - Command owner set by host, cleared here
// - Response owner cleared here, host sets it
// - Poll register read starts command scan
// - Any poll register write reinitializes
// - Interrupt when command ring frees a slot
// - Interrupt when response ring gains response
// - Interrupt at initialization and fatal faults
// - Read buffer length, fragment long responses
// - Skip size check for short responses
// - Envelope words: connection, type, credit
// - Move command data by DMA
// - Start value begins four-step handshake
// - Word zero: rings, arming, vector; self test
// - Step two echoes ring lengths; low base
// - Step three echoes vector; high base, poll test
// - Word three: burst, last fail, go (only go is decoded, burst and last fail are ignored); clear area
// - Fatal init fault flashes indicator, shows code
`timescale 1ns/100ps
`include "rmh_consts.svh"
module rmh_port #(
  parameter int RING_W    = 7,
  parameter int FLASH_CYC = (`RMH_FLASH_MS * 1000000) / `RMH_CLK_NS
) (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Sync reset
  input  wire logic        bus_init,     // Host bus initialize
  input  wire logic        host_sel,     // 0 poll register, 1 status register
  input  wire logic        host_rd,      // Register read strobe
  input  wire logic        host_wr,      // Register write strobe
  input  wire logic [15:0] host_wdata,   // Register write data
  output logic      [15:0] host_rdata_q, // Register read data
  output logic             host_irq_q,   // Interrupt request pulse
  output logic      [6:0]  irq_vec_q,    // Interrupt vector
  output logic             mem_req_q,    // Host memory request
  output logic             mem_we_q,     // Request is a write
  output logic      [21:0] mem_addr_q,   // Byte address
  output logic      [31:0] mem_wdata_q,  // Write data
  input  wire logic        mem_ack,      // Access done
  input  wire logic [31:0] mem_rdata,    // Read data with ack
  input  wire logic        mem_err,      // Bus or mastership failure
  input  wire logic        mem_parity,   // Bus parity error
  input  wire logic        ram_fail,     // Buffer RAM test result
  input  wire logic        cache_fail,   // Cache test result
  output logic             cmd_valid_q,  // Command taken pulse
  output logic      [21:0] cmd_env_q,    // Command envelope address
  output logic      [15:0] cmd_len_q,    // Command length in bytes
  output logic      [15:0] cmd_conn_q,   // Command connection
  output logic      [15:0] credit_q,     // Credit count
  input  wire logic        rsp_valid,    // Response waiting
  input  wire logic [15:0] rsp_len,      // Response length in bytes
  input  wire logic [15:0] rsp_conn,     // Response connection
  input  wire logic [1:0]  rsp_type,     // Response message type
  output logic             rsp_ack_q,    // Response taken pulse
  input  wire logic        xfer_start,   // Data move request
  input  wire logic [21:0] xfer_addr,    // Host buffer address
  input  wire logic [15:0] xfer_words,   // Words to move
  input  wire logic        xfer_to_host, // Direction
  input  wire logic [31:0] dsk_wdata,    // Disc word toward host
  output logic             xfer_ack_q,   // Move taken pulse
  output logic             dsk_take_q,   // Disc word consumed pulse
  output logic      [31:0] dsk_rdata_q,  // Host word toward disc
  output logic             dsk_valid_q,  // Host word valid pulse
  output logic             online_q,     // Handshake complete
  output logic             err_led_q     // Fatal indicator
);
  rmh_pkg::rmh_state_t state_q;
  logic [15:0] sa_q;
  logic [2:0]  clen_q, rlen_q;
  logic        arm_q, poll_q, ptest_q, cflag_q, rflag_q;
  logic [21:0] base_q, env_q, xaddr_q;
  logic [15:0] rem_q, buf_q, xcnt_q, rconn_q;
  logic [1:0]  rtype_q;
  logic        xdir_q;
  logic [8:0]  clr_q;
  logic [RING_W-1:0] cidx, ridx;
  logic        reinit, ip_rd, sa_wr, acc_en, acc_we, cadv, radv, fatal;
  logic [21:0] acc_addr;
  logic [31:0] acc_wdata, ret_desc;
  logic [15:0] frag, fcode, bufsz;
  logic [8:0]  clr_last;

  initial
  begin
    if (RING_W < 1 || RING_W > 7)
      $error("rmh_port: RING_W must be 1..7");
  end

  function automatic logic [21:0] f_slot(input logic [21:0] b, input logic [8:0] n);
    return b + {11'h000, n, 2'b00};
  endfunction

  function automatic logic [21:0] f_env(input logic [31:0] d);
    return {d[21:1], 1'b0};
  endfunction

  assign reinit   = bus_init || (host_wr && host_sel == `RMH_SEL_IP);
  assign ip_rd    = host_rd && host_sel == `RMH_SEL_IP;
  assign sa_wr    = host_wr && host_sel == `RMH_SEL_SA;
  assign bufsz    = (buf_q == 16'h0000) ? rem_q : buf_q;
  assign frag     = (rem_q > bufsz) ? bufsz : rem_q;
  assign ret_desc = {1'b0, 1'b1, 8'h00, env_q};
  assign clr_last = 9'((32'd1 << clen_q) + (32'd1 << rlen_q) - 32'd1);
  assign cadv     = state_q == rmh_pkg::S_CDONE && mem_ack;
  assign radv     = state_q == rmh_pkg::S_RDONE && mem_ack;

  rmh_ring_idx #(.W(RING_W)) u_cidx (
    .clk      (clk),
    .rst      (rst),
    .clr      (reinit),
    .adv      (cadv),
    .len_log2 (clen_q),
    .idx_q    (cidx)
  );

  rmh_ring_idx #(.W(RING_W)) u_ridx (
    .clk      (clk),
    .rst      (rst),
    .clr      (reinit),
    .adv      (radv),
    .len_log2 (rlen_q),
    .idx_q    (ridx)
  );

  rmh_fault #(.FLASH_CYC(FLASH_CYC)) u_fault (
    .clk        (clk),
    .rst        (rst || reinit),
    .ram_fail   (state_q == rmh_pkg::S_STEP1 && sa_wr && ram_fail),
    .cache_fail (state_q == rmh_pkg::S_STEP1 && sa_wr && cache_fail),
    .bus_fail   (mem_req_q && mem_err),
    .parity     (mem_req_q && mem_parity),
    .fatal_q    (fatal),
    .code_q     (fcode),
    .led_q      (err_led_q)
  );

  // One memory access per state, except S_CLR, S_XFER and S_RDESC, which repeat theirs; response ring sits first, command ring after it
  always_comb
  begin
    acc_en    = 1'b1;
    acc_we    = 1'b0;
    acc_addr  = env_q;
    acc_wdata = 32'h0000_0000;
    unique case (state_q)
      rmh_pkg::S_DTEST: acc_addr = base_q;
      rmh_pkg::S_CLR:
      begin
        acc_we   = 1'b1;
        acc_addr = f_slot(base_q, clr_q);
      end
      rmh_pkg::S_CDESC:
        acc_addr = f_slot(base_q, 9'((32'd1 << rlen_q) + 32'(cidx)));
      rmh_pkg::S_CENV0: acc_addr = env_q;
      rmh_pkg::S_CENV1: acc_addr = env_q + 22'h00_0004;
      rmh_pkg::S_RDESC: acc_addr = f_slot(base_q, 9'(ridx));
      rmh_pkg::S_RBUF: acc_addr = env_q;
      rmh_pkg::S_RENV0:
      begin
        acc_we    = 1'b1;
        acc_wdata = {rconn_q, frag};
      end
      rmh_pkg::S_RENV1:
      begin
        acc_we    = 1'b1;
        acc_addr  = env_q + 22'h00_0004;
        acc_wdata = {16'h0001, 14'h0000, rtype_q};
      end
      rmh_pkg::S_CDONE:
      begin
        acc_we    = 1'b1;
        acc_addr  = f_slot(base_q, 9'((32'd1 << rlen_q) + 32'(cidx)));
        acc_wdata = ret_desc;
      end
      rmh_pkg::S_RDONE:
      begin
        acc_we    = 1'b1;
        acc_addr  = f_slot(base_q, 9'(ridx));
        acc_wdata = ret_desc;
      end
      rmh_pkg::S_XFER:
      begin
        acc_en    = xcnt_q != 16'h0000;
        acc_we    = xdir_q;
        acc_addr  = xaddr_q;
        acc_wdata = dsk_wdata;
      end
      default: acc_en = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || reinit || fatal || mem_ack)
      mem_req_q <= 1'b0;
    else if (acc_en && !mem_req_q)
    begin
      mem_req_q   <= 1'b1;
      mem_we_q    <= acc_we;
      mem_addr_q  <= acc_addr;
      mem_wdata_q <= acc_wdata;
    end
    if (rst)
    begin
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 22'h00_0000;
      mem_wdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || reinit)
      poll_q <= 1'b0;
    else if (online_q && ip_rd)
      poll_q <= 1'b1;
    else if (state_q == rmh_pkg::S_CDESC && mem_ack && !mem_rdata[`RMH_D_OWN])
      poll_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    host_rdata_q <= (rst || host_sel == `RMH_SEL_IP) ? 16'h0000 : sa_q;
  end

  always_ff @(posedge clk)
  begin
    host_irq_q  <= 1'b0;
    cmd_valid_q <= 1'b0;
    rsp_ack_q   <= 1'b0;
    xfer_ack_q  <= 1'b0;
    dsk_take_q  <= 1'b0;
    dsk_valid_q <= 1'b0;
    if (rst)
    begin
      state_q <= rmh_pkg::S_IDLE;
      sa_q <= 16'h0000;
      {clen_q, rlen_q, arm_q, ptest_q, cflag_q, rflag_q, xdir_q} <= '0;
      {base_q, env_q, xaddr_q, cmd_env_q} <= '0;
      {rem_q, buf_q, xcnt_q, rconn_q, cmd_len_q, cmd_conn_q, credit_q} <= '0;
      {irq_vec_q, rtype_q, clr_q, online_q} <= '0;
      dsk_rdata_q <= 32'h0000_0000;
    end
    else if (reinit)
    begin
      state_q  <= rmh_pkg::S_STEP1;
      sa_q     <= `RMH_STEP1;
      online_q <= 1'b0;
      credit_q <= 16'h0000;
    end
    else if (fatal && state_q != rmh_pkg::S_FATAL)
    begin
      state_q    <= rmh_pkg::S_FATAL;
      sa_q       <= fcode;
      online_q   <= 1'b0;
      host_irq_q <= arm_q;
    end
    else
    begin
      unique case (state_q)
        rmh_pkg::S_IDLE, rmh_pkg::S_FATAL: ;
        rmh_pkg::S_STEP1:
          if (sa_wr)
          begin
            clen_q     <= host_wdata[`RMH_W0_CLEN];
            rlen_q     <= host_wdata[`RMH_W0_RLEN];
            arm_q      <= host_wdata[`RMH_W0_ARM];
            irq_vec_q  <= host_wdata[`RMH_W0_VEC];
            host_irq_q <= host_wdata[`RMH_W0_ARM] && !ram_fail && !cache_fail;
            state_q    <= rmh_pkg::S_STEP2;
            sa_q       <= `RMH_STEP2 | {10'h000, host_wdata[13:8]};
          end
        rmh_pkg::S_STEP2:
          if (sa_wr)
          begin
            base_q[15:0] <= {host_wdata[15:1], 1'b0};
            state_q      <= rmh_pkg::S_STEP3;
            sa_q         <= `RMH_STEP3 | {8'h00, arm_q, irq_vec_q};
          end
        rmh_pkg::S_STEP3:
          if (sa_wr)
          begin
            base_q[21:16] <= host_wdata[`RMH_W2_HIGH];
            ptest_q       <= host_wdata[`RMH_W2_POLL];
            state_q       <= rmh_pkg::S_STEP4;
            sa_q          <= `RMH_STEP4;
          end
        rmh_pkg::S_STEP4:
          if (sa_wr && host_wdata[`RMH_W3_GO])
            state_q <= rmh_pkg::S_DTEST;
        rmh_pkg::S_DTEST:
          if (mem_ack)
          begin
            clr_q   <= 9'h000;
            state_q <= rmh_pkg::S_CLR;
          end
        rmh_pkg::S_CLR:
          if (mem_ack)
          begin
            clr_q <= clr_q + 9'h001;
            if (clr_q == clr_last)
            begin
              state_q    <= ptest_q ? rmh_pkg::S_CDESC : rmh_pkg::S_RUN;
              sa_q       <= 16'h0000;
              online_q   <= 1'b1;
              host_irq_q <= arm_q;
            end
          end
        rmh_pkg::S_RUN:
          if (xfer_start)
          begin
            xaddr_q    <= xfer_addr;
            xcnt_q     <= xfer_words;
            xdir_q     <= xfer_to_host;
            xfer_ack_q <= 1'b1;
            state_q    <= rmh_pkg::S_XFER;
          end
          else if (rsp_valid)
          begin
            rem_q     <= rsp_len;
            rconn_q   <= rsp_conn;
            rtype_q   <= rsp_type;
            rsp_ack_q <= 1'b1;
            state_q   <= rmh_pkg::S_RDESC;
          end
          else if (poll_q)
            state_q <= rmh_pkg::S_CDESC;
        rmh_pkg::S_CDESC:
          if (mem_ack)
          begin
            env_q   <= f_env(mem_rdata);
            cflag_q <= mem_rdata[`RMH_D_FLAG];
            state_q <= mem_rdata[`RMH_D_OWN] ? rmh_pkg::S_CENV0 : rmh_pkg::S_RUN;
          end
        rmh_pkg::S_CENV0:
          if (mem_ack)
          begin
            cmd_len_q  <= mem_rdata[15:0];
            cmd_conn_q <= mem_rdata[31:16];
            state_q    <= rmh_pkg::S_CENV1;
          end
        rmh_pkg::S_CENV1:
          if (mem_ack)
          begin
            // Credit notices carry no work, so their credit is not counted
            if (mem_rdata[1:0] != 2'(rmh_pkg::RMH_CREDIT_MSG_TYPE))
              credit_q <= credit_q + mem_rdata[31:16];
            state_q <= rmh_pkg::S_CDONE;
          end
        rmh_pkg::S_CDONE:
          if (mem_ack)
          begin
            cmd_env_q   <= env_q;
            cmd_valid_q <= 1'b1;
            host_irq_q  <= cflag_q && arm_q;
            state_q     <= rmh_pkg::S_CDESC;
          end
        rmh_pkg::S_RDESC:
          if (mem_ack && mem_rdata[`RMH_D_OWN])
          begin
            env_q   <= f_env(mem_rdata);
            rflag_q <= mem_rdata[`RMH_D_FLAG];
            buf_q   <= rem_q;
            // Short answers always fit, so the length read is skipped
            state_q <= (rem_q > `RMH_NOCHK_BYTES) ? rmh_pkg::S_RBUF : rmh_pkg::S_RENV0;
          end
        rmh_pkg::S_RBUF:
          if (mem_ack)
          begin
            buf_q   <= mem_rdata[15:0];
            state_q <= rmh_pkg::S_RENV0;
          end
        rmh_pkg::S_RENV0:
          if (mem_ack)
            state_q <= rmh_pkg::S_RENV1;
        rmh_pkg::S_RENV1:
          if (mem_ack)
            state_q <= rmh_pkg::S_RDONE;
        rmh_pkg::S_RDONE:
          if (mem_ack)
          begin
            rem_q      <= rem_q - frag;
            host_irq_q <= rflag_q && arm_q;
            state_q    <= (rem_q == frag) ? rmh_pkg::S_RUN : rmh_pkg::S_RDESC;
          end
        rmh_pkg::S_XFER:
          if (xcnt_q == 16'h0000)
            state_q <= rmh_pkg::S_RUN;
          else if (mem_ack)
          begin
            xcnt_q      <= xcnt_q - 16'h0001;
            xaddr_q     <= xaddr_q + 22'h00_0004;
            dsk_take_q  <= xdir_q;
            dsk_valid_q <= !xdir_q;
            dsk_rdata_q <= mem_rdata;
          end
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_desc_flag_set: assert property (
    (mem_req_q && (state_q == rmh_pkg::S_CDONE || state_q == rmh_pkg::S_RDONE))
      |-> mem_we_q && mem_wdata_q[`RMH_D_FLAG] && !mem_wdata_q[`RMH_D_OWN])
    else $error("returned descriptor not flagged or still owned");
  a_env_even: assert property (
    (mem_req_q && state_q inside {rmh_pkg::S_CENV0, rmh_pkg::S_RBUF, rmh_pkg::S_RENV0})
      |-> !mem_addr_q[0])
    else $error("envelope address is odd");
  a_ip_write_reinit: assert property (
    (host_wr && host_sel == `RMH_SEL_IP) |=> state_q == rmh_pkg::S_STEP1 && sa_q == `RMH_STEP1)
    else $error("poll register write did not reinitialize");
  a_ip_read_poll: assert property (
    (state_q == rmh_pkg::S_RUN && ip_rd && !reinit && !fatal)
      |=> poll_q || state_q != rmh_pkg::S_RUN)
    else $error("poll register read did not start a scan");
  a_step2_echo: assert property (
    state_q == rmh_pkg::S_STEP2 |-> sa_q == (`RMH_STEP2 | {10'h000, clen_q, rlen_q}))
    else $error("ring lengths not echoed");
  a_frag_fits: assert property (
    (mem_req_q && state_q == rmh_pkg::S_RENV0) |-> mem_wdata_q[15:0] <= bufsz)
    else $error("response fragment longer than buffer");
  a_fatal_code: assert property (
    $rose(state_q == rmh_pkg::S_FATAL) |-> sa_q == fcode && !online_q)
    else $error("fatal code not shown");
  a_irq_armed: assert property (
    host_irq_q |-> arm_q || state_q == rmh_pkg::S_STEP2)
    else $error("interrupt raised while not armed");
  a_cmd_taken: assert property (
    (state_q == rmh_pkg::S_CDONE && mem_ack && !reinit && !fatal) |=> cmd_valid_q ##1 !cmd_valid_q)
    else $error("consumed command not reported once");
endmodule

// ### testbench/rmh_mem_model.sv
`timescale 1ns/100ps
module rmh_mem_model (
  input  wire logic        clk,   // System clock
  input  wire logic        rst,   // Sync reset
  input  wire logic        slow,  // Stretch each access
  input  wire logic        req,   // Access request
  input  wire logic        we,    // Write access
  input  wire logic [21:0] addr,  // Byte address
  input  wire logic [31:0] wdata, // Write data
  output logic             ack,   // Access done pulse
  output logic      [31:0] rdata  // Read data with ack
);
  logic [31:0] mem [0:255];
  logic [2:0]  wait_q;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h0;
  end
  always @(posedge clk)
  begin
    ack <= 1'b0;
    // Released bus never repeats the last word
    rdata <= rst ? 32'h5A5A_A5A5 : ~rdata;
    if (rst)
      wait_q <= 3'h0;
    else if (req && !ack)
    begin
      wait_q <= wait_q + 3'h1;
      if (wait_q >= (slow ? 3'h3 : 3'h0))
      begin
        ack <= 1'b1;
        wait_q <= 3'h0;
        if (we)
          mem[addr[9:2]] <= wdata;
        else
          rdata <= mem[addr[9:2]];
      end
    end
  end
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, rst, bus_init, host_sel, host_rd, host_wr, mem_ack, mem_req_q, mem_we_q, slow;
  logic ram_fail, rsp_valid, xfer_start, xfer_to_host, host_irq_q, cmd_valid_q, rsp_ack_q;
  logic xfer_ack_q, dsk_take_q, online_q, err_led_q;
  logic [15:0] host_wdata, host_rdata_q, cmd_len_q, cmd_conn_q, credit_q, v;
  logic [15:0] rsp_len, rsp_conn, xfer_words;
  logic [1:0]  rsp_type;
  logic [6:0]  irq_vec_q;
  logic        dsk_valid_q;
  logic [21:0] mem_addr_q, cmd_env_q, xfer_addr;
  logic [31:0] mem_wdata_q, mem_rdata, dsk_wdata, dsk_rdata_q;
  int err_count, checks, irqs, n;
  rmh_port #(.FLASH_CYC(4)) i_rmh_port (.clk(clk), .rst(rst), .bus_init(bus_init),
    .host_sel(host_sel), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_irq_q(host_irq_q), .irq_vec_q(irq_vec_q),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(1'b0),
    .mem_parity(1'b0), .ram_fail(ram_fail), .cache_fail(1'b0), .cmd_valid_q(cmd_valid_q),
    .cmd_env_q(cmd_env_q), .cmd_len_q(cmd_len_q), .cmd_conn_q(cmd_conn_q),
    .credit_q(credit_q), .rsp_valid(rsp_valid), .rsp_len(rsp_len), .rsp_conn(rsp_conn),
    .rsp_type(rsp_type), .rsp_ack_q(rsp_ack_q), .xfer_start(xfer_start),
    .xfer_addr(xfer_addr), .xfer_words(xfer_words), .xfer_to_host(xfer_to_host),
    .dsk_wdata(dsk_wdata), .xfer_ack_q(xfer_ack_q), .dsk_take_q(dsk_take_q),
    .dsk_rdata_q(dsk_rdata_q), .dsk_valid_q(dsk_valid_q), .online_q(online_q),
    .err_led_q(err_led_q));
  rmh_mem_model i_rmh_mem_model (.clk(clk), .rst(rst), .slow(slow), .req(mem_req_q),
    .we(mem_we_q), .addr(mem_addr_q), .wdata(mem_wdata_q), .ack(mem_ack),
    .rdata(mem_rdata));
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic s, input logic [15:0] d);
    @(posedge clk);
    host_sel <= s;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask
  task rd_sa;
    @(posedge clk);
    host_sel <= 1'b1;
    repeat (3) @(posedge clk);
    #1 v = host_rdata_q;
  endtask
  task init_seq;
    wr(1'b0, 16'h0800);
    rd_sa;
    chk("step1", 32'h0800, v);
    wr(1'b1, 16'h09D5);
    rd_sa;
    chk("step2", 32'h1009, v);
    chk("irq_vec", 32'h55, {25'h0, irq_vec_q});
    wr(1'b1, 16'h0040);
    rd_sa;
    chk("step3", 32'h20D5, v);
    wr(1'b1, 16'h0000);
    rd_sa;
    chk("step4", 32'h4000, v);
    wr(1'b1, 16'h0001);
    n = 0;
    while (n < 3000 && online_q !== 1'b1) begin @(posedge clk); #1; n++; end
    chk("online", 32'h1, {31'h0, online_q});
    // The completion pulse is counted at the edge after online rises
    @(posedge clk);
    #1 chk("init_irqs", 32'h2, irqs);
  endtask
  task command_scan;
    slow <= 1'b1;
    i_rmh_mem_model.mem[8'h12] = 32'hC000_0101;
    i_rmh_mem_model.mem[8'h40] = 32'h1234_0020;
    i_rmh_mem_model.mem[8'h41] = 32'h0001_0003;
    @(posedge clk);
    host_sel <= 1'b0;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    n = 0;
    while (n < 3000 && cmd_valid_q !== 1'b1) begin @(posedge clk); #1; n++; end
    chk("cmd_env", 32'h100, cmd_env_q);
    chk("cmd_len", 32'h20, cmd_len_q);
    chk("cmd_conn", 32'h1234, cmd_conn_q);
    repeat (20) @(posedge clk);
    chk("cmd_desc", 32'h4000_0100, i_rmh_mem_model.mem[8'h12]);
    chk("credit", 32'h1, credit_q);
    chk("cmd_irq", 32'h3, irqs);
    slow <= 1'b0;
  endtask
  task response;
    i_rmh_mem_model.mem[8'h10] = 32'hC000_0180;
    i_rmh_mem_model.mem[8'h60] = 32'h0000_0040;
    @(posedge clk);
    rsp_valid <= 1'b1;
    n = 0;
    while (n < 3000 && rsp_ack_q !== 1'b1) begin @(posedge clk); #1; n++; end
    rsp_valid <= 1'b0;
    repeat (40) @(posedge clk);
    chk("rsp_env0", 32'h0BEE_0010, i_rmh_mem_model.mem[8'h60]);
    chk("rsp_env1", 32'h0001_0002, i_rmh_mem_model.mem[8'h61]);
    chk("rsp_desc", 32'h4000_0180, i_rmh_mem_model.mem[8'h10]);
    chk("rsp_irq", 32'h4, irqs);
  endtask
  task response_long;
    i_rmh_mem_model.mem[8'h11] = 32'hC000_01A0;
    i_rmh_mem_model.mem[8'h68] = 32'h0000_0040;
    rsp_len <= 16'h0050;
    @(posedge clk);
    rsp_valid <= 1'b1;
    n = 0;
    while (n < 3000 && rsp_ack_q !== 1'b1) begin @(posedge clk); #1; n++; end
    rsp_valid <= 1'b0;
    repeat (40) @(posedge clk);
    chk("frag_env0", 32'h0BEE_0040, i_rmh_mem_model.mem[8'h68]);
    chk("frag_desc", 32'h4000_01A0, i_rmh_mem_model.mem[8'h11]);
    // Slot zero is handed back only now, so the tail waits for it
    #1 i_rmh_mem_model.mem[8'h70] = 32'h0000_0040;
    i_rmh_mem_model.mem[8'h10] = 32'hC000_01C0;
    repeat (40) @(posedge clk);
    chk("frag_tail", 32'h0BEE_0010, i_rmh_mem_model.mem[8'h70]);
    chk("frag_irqs", 32'h6, irqs);
  endtask
  task dma_move;
    @(posedge clk);
    xfer_start <= 1'b1;
    n = 0;
    while (n < 3000 && xfer_ack_q !== 1'b1) begin @(posedge clk); #1; n++; end
    xfer_start <= 1'b0;
    n = 0;
    while (n < 3000 && dsk_take_q !== 1'b1) begin @(posedge clk); #1; n++; end
    chk("dma_word", 32'hA55A_F00F, i_rmh_mem_model.mem[8'h80]);
    xfer_to_host <= 1'b0;
    @(posedge clk);
    xfer_start <= 1'b1;
    n = 0;
    while (n < 3000 && xfer_ack_q !== 1'b1) begin @(posedge clk); #1; n++; end
    xfer_start <= 1'b0;
    n = 0;
    while (n < 3000 && dsk_valid_q !== 1'b1) begin @(posedge clk); #1; n++; end
    chk("dma_read", 32'hA55A_F00F, dsk_rdata_q);
  endtask
  task fatal_then_reinit;
    ram_fail <= 1'b1;
    wr(1'b0, 16'h0000);
    wr(1'b1, 16'h09D5);
    rd_sa;
    chk("fatal_code", 32'hAB0B, v);
    v[0] = err_led_q;
    repeat (12) @(posedge clk);
    #1 chk("led_flash", {31'h0, ~v[0]}, {31'h0, err_led_q});
    ram_fail <= 1'b0;
    bus_init <= 1'b1;
    @(posedge clk);
    bus_init <= 1'b0;
    rd_sa;
    chk("reinit", 32'h0800, v);
    chk("offline", 32'h0, {31'h0, online_q});
    chk("led_off", 32'h0, {31'h0, err_led_q});
  endtask
  always @(posedge clk)
    if (host_irq_q === 1'b1)
      irqs++;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #200000;
    err_count++;
    test_done;
  end
  initial
  begin
    {rst, bus_init, host_sel, host_rd, host_wr, slow, ram_fail, rsp_valid} = 8'hFF & 8'h80;
    xfer_start = 1'b0;
    host_wdata = 16'h0;
    {rsp_len, rsp_conn, rsp_type} = {16'h0010, 16'h0BEE, 2'h2};
    {xfer_addr, xfer_words, xfer_to_host} = {22'h000200, 16'h0001, 1'b1};
    dsk_wdata = 32'hA55A_F00F;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    init_seq;
    command_scan;
    response;
    response_long;
    dma_move;
    fatal_then_reinit;
    test_done;
  end
endmodule
